// *** hw/ddr2c_pkg.sv ***
// Shared constants, command codes and carrier types for the DDR2 control input logic.
// Assumes one 40 MHz CLOCK that stands for the rising crossing of the differential clock pair.
package ddr2c_pkg;

  // ----------------------------------------------------------------------------
  // Widths and timing.
  // ----------------------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int BA_W = 3;
  localparam int NBANK = 8;
  localparam int DQ_W = 8;
  localparam int CLK_PERIOD_PS = 25000;
  // Settling time of internal clocks and buffers after self-refresh exit.
  localparam int WAKE_NS = 100;
  localparam int WAKE_CYC = (WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Clock cycles of write data after a write command (burst of four beats).
  localparam int BURST_CYC = 2;

  // ----------------------------------------------------------------------------
  // Command codes as {chip select, row strobe, column strobe, write enable}.
  // ----------------------------------------------------------------------------
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;

  // ----------------------------------------------------------------------------
  // Address fields and mode register layout.
  // ----------------------------------------------------------------------------
  localparam int AP_BIT = 10;
  localparam int EMR1_RTT0_BIT = 2;
  localparam int EMR1_RTT1_BIT = 6;
  localparam int EMR1_RDQS_BIT = 11;
  localparam logic [1:0] MR_SEL_EMR1 = 2'h1;
  localparam logic [13:0] MR_RST = 14'h0000;

  // ----------------------------------------------------------------------------
  // Carrier types.
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [13:0] addr;
    logic odt;
  } ddr2c_cmd_t;

  typedef struct packed {
    logic [7:0] dq_rise;
    logic [7:0] dq_fall;
    logic dm_rise;
    logic dm_fall;
  } ddr2c_beat_t;

  typedef struct packed {
    logic int_clk;
    logic in_buf;
    logic clk_buf;
    logic odt_buf;
    logic out_drv;
  } ddr2c_power_t;

  typedef enum logic [4:0] {
    ST_RUN = 5'b00001,
    ST_PDP = 5'b00010,
    ST_PDA = 5'b00100,
    ST_SR = 5'b01000,
    ST_WAKE = 5'b10000
  } ddr2c_state_t;

endpackage

// *** hw/ddr2c_sync.sv ***
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes the bits are independent levels; only the second stage is read outside.
`timescale 1ns/1ps
module ddr2c_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  // Next values; the first stage feeds the second stage and nothing else.
  always_comb
  begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  // Both stages freeze with the clock enable.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else if (clock_en)
    begin
      meta_r <= meta_nxt;
      q <= q_nxt;
    end
  end

endmodule

// *** hw/ddr2c_wmask.sv ***
// Write data masking for one rising and one falling beat per clock.
// Assumes beats are already synchronised and valid only inside a write burst.
`timescale 1ns/1ps
module ddr2c_wmask #(
  parameter int DW = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  input wire logic beat_valid,
  input wire logic dm_en,
  input wire logic [DW-1:0] dq_rise,
  input wire logic [DW-1:0] dq_fall,
  input wire logic dm_rise,
  input wire logic dm_fall,
  output logic store_rise,
  output logic store_fall,
  output logic [DW-1:0] data_rise,
  output logic [DW-1:0] data_fall
);

  logic store_rise_nxt;
  logic store_fall_nxt;

  // Each beat carries its own mask bit, one per strobe edge.
  // A masked beat is never stored; with the pin used as read strobe no mask applies.
  always_comb
  begin
    store_rise_nxt = beat_valid && !(dm_en && dm_rise);
    store_fall_nxt = beat_valid && !(dm_en && dm_fall);
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      store_rise <= 1'b0;
      store_fall <= 1'b0;
      data_rise <= '0;
      data_fall <= '0;
    end
    else if (clock_en)
    begin
      store_rise <= store_rise_nxt;
      store_fall <= store_fall_nxt;
      data_rise <= dq_rise;
      data_fall <= dq_fall;
    end
  end

  property p_mask_fall;
    @(posedge clock) disable iff (!resetn || !clock_en)
    (beat_valid && dm_en && dm_fall) |=> !store_fall;
  endproperty
  a_mask_fall: assert property (p_mask_fall) else $error("masked falling beat was stored");

  property p_mask_rise;
    @(posedge clock) disable iff (!resetn || !clock_en)
    (beat_valid && !(dm_en && dm_rise)) |=> store_rise && data_rise == $past(dq_rise);
  endproperty
  a_mask_rise: assert property (p_mask_rise) else $error("unmasked rising beat lost");

endmodule

// *** hw/ddr2c_top.sv ***
// Control input logic of a DDR2 SDRAM: command sampling, clock-enable power states and masking.
// Assumes pins arrive unsynchronised and read data arrives from array logic on CLOCK.
//
// How it works
// - Address and control pins are captured on the rising clock edge only.
// - Read data leaves as a rising and a falling beat per clock.
// - Clock enable high runs clocks, buffers and drivers; low stops internal clocks, input buffers and drivers.
// - Clock enable low: idle banks give precharge power-down or self refresh, else active.
// - Power-down entry/exit and self-refresh entry are clocked; self-refresh exit needs no command.
// - Power-down keeps only clock, termination and clock-enable buffers alive.
// - Self refresh keeps only the clock-enable buffer alive.
// - Chip select high masks every command; it is part of the code.
// - Row strobe, column strobe, write enable and chip select form the command.
// - Termination pin high switches on termination of data, strobe and mask pins.
// - Termination pin is ignored when the extended mode register disables it.
// - A write beat with mask high at that beat is not stored.
// - The mask is taken on both strobe edges.
// - On x8 the mask pin serves as mask or read strobe per mode bit.
// - Bank address picks the bank of activate, read, write and precharge.
// - Bank address picks base or extended mode register in a mode set.
// - Precharge with address bit ten high closes all banks, low one bank.
// - Activate takes the row; read/write take column and auto-precharge bit.
`timescale 1ns/1ps
module ddr2c_top #(
  parameter int WAKE_CYC = ddr2c_pkg::WAKE_CYC,
  parameter int BURST_CYC = ddr2c_pkg::BURST_CYC
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic CLOCK_EN,
  input wire logic CKE,
  input wire ddr2c_pkg::ddr2c_cmd_t CMD_PINS,
  input wire ddr2c_pkg::ddr2c_beat_t WR_BEAT,
  input wire logic RD_VALID,
  input wire logic [7:0] RD_DATA_RISE,
  input wire logic [7:0] RD_DATA_FALL,
  output logic CMD_STROBE,
  output logic [3:0] CMD_CODE,
  output logic [2:0] CMD_BANK,
  output logic [13:0] CMD_ADDR,
  output logic CMD_AUTO_PRE,
  output logic [7:0] BANK_OPEN,
  output logic [13:0] MODE_BASE,
  output logic [13:0] MODE_EXT1,
  output ddr2c_pkg::ddr2c_power_t POWER,
  output ddr2c_pkg::ddr2c_state_t PWR_STATE,
  output logic ODT_ON,
  output logic [7:0] DQ_O_RISE,
  output logic [7:0] DQ_O_FALL,
  output logic DQ_OE_N,
  output logic RDQS_O,
  output logic RDQS_OE_N,
  output logic WR_STORE_RISE,
  output logic WR_STORE_FALL,
  output logic [7:0] WR_DATA_RISE,
  output logic [7:0] WR_DATA_FALL
);

  // ----------------------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------------------
  ddr2c_pkg::ddr2c_cmd_t cmd_s;
  ddr2c_pkg::ddr2c_beat_t beat_s;
  logic cke_s;

  // The clock enable pin shares the command synchroniser, which runs in every state, so it can be watched in every state.
  ddr2c_sync #(.W($bits(ddr2c_pkg::ddr2c_cmd_t) + 1)) u_sync_cmd (
    .clock(CLOCK),
    .resetn(RESETN),
    .clock_en(CLOCK_EN),
    .d({CMD_PINS, CKE}),
    .q({cmd_s, cke_s})
  );

  ddr2c_sync #(.W($bits(ddr2c_pkg::ddr2c_beat_t))) u_sync_beat (
    .clock(CLOCK),
    .resetn(RESETN),
    .clock_en(CLOCK_EN),
    .d(WR_BEAT),
    .q(beat_s)
  );

  // ----------------------------------------------------------------------------
  // Command decode.
  // ----------------------------------------------------------------------------
  ddr2c_pkg::ddr2c_state_t state_r;
  ddr2c_pkg::ddr2c_state_t state_nxt;
  logic [3:0] code;
  logic run;
  logic exec;
  logic all_idle;
  logic [7:0] open_r;
  logic [7:0] open_nxt;
  logic [13:0] mr_r [4];
  logic [13:0] mr_nxt [4];

  // Chip select is the top bit of the code, so a high select never matches a command.
  assign code = {cmd_s.cs_n, cmd_s.ras_n, cmd_s.cas_n, cmd_s.we_n};
  // Commands count only in the running state with clock enable still high.
  assign run = (state_r == ddr2c_pkg::ST_RUN);
  assign exec = run && cke_s;
  assign all_idle = (open_r == 8'h00);

  // ----------------------------------------------------------------------------
  // Bank state: one open flag per bank, updated by index.
  // ----------------------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < ddr2c_pkg::NBANK; b = b + 1)
    begin : g_bank
      logic hit;
      assign hit = (cmd_s.ba == 3'(b));
      assign open_nxt[b] = !exec ? open_r[b] :
                           (code == ddr2c_pkg::CMD_ACT && hit) ? 1'b1 :
                           (code == ddr2c_pkg::CMD_PRE && (hit || cmd_s.addr[ddr2c_pkg::AP_BIT])) ? 1'b0 :
                           ((code == ddr2c_pkg::CMD_RD || code == ddr2c_pkg::CMD_WR) && hit &&
                            cmd_s.addr[ddr2c_pkg::AP_BIT]) ? 1'b0 : open_r[b];
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Mode registers, chosen by the low bank address bits.
  // ----------------------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      mr_nxt[i] = mr_r[i];
    end
    // Mode set is only legal with all banks idle; otherwise it is dropped.
    if (exec && code == ddr2c_pkg::CMD_MRS && all_idle && !cmd_s.ba[2])
    begin
      mr_nxt[cmd_s.ba[1:0]] = cmd_s.addr;
    end
  end

  // ----------------------------------------------------------------------------
  // Power state machine.
  // ----------------------------------------------------------------------------
  logic [7:0] wake_r;
  logic [7:0] wake_nxt;

  // Entry and power-down exit follow the sampled clock enable; self-refresh exit
  // needs only the enable level, no command and no clock-dependent qualifier.
  always_comb
  begin
    state_nxt = state_r;
    wake_nxt = wake_r;
    case (state_r)
      ddr2c_pkg::ST_RUN:
      begin
        if (!cke_s)
        begin
          if (all_idle && code == ddr2c_pkg::CMD_REF)
          begin
            state_nxt = ddr2c_pkg::ST_SR;
          end
          else if (all_idle)
          begin
            state_nxt = ddr2c_pkg::ST_PDP;
          end
          else
          begin
            state_nxt = ddr2c_pkg::ST_PDA;
          end
        end
      end
      ddr2c_pkg::ST_PDP, ddr2c_pkg::ST_PDA:
      begin
        if (cke_s)
        begin
          state_nxt = ddr2c_pkg::ST_RUN;
        end
      end
      ddr2c_pkg::ST_SR:
      begin
        if (cke_s)
        begin
          state_nxt = ddr2c_pkg::ST_WAKE;
          wake_nxt = 8'(WAKE_CYC - 1);
        end
      end
      ddr2c_pkg::ST_WAKE:
      begin
        // Clocks and buffers settle here; any command seen now is dropped.
        if (wake_r == 8'h00)
        begin
          state_nxt = ddr2c_pkg::ST_RUN;
        end
        else
        begin
          wake_nxt = wake_r - 8'h01;
        end
      end
      default:
      begin
        state_nxt = ddr2c_pkg::ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // Buffer and driver enables, termination, strobes and outputs.
  // ----------------------------------------------------------------------------
  ddr2c_pkg::ddr2c_power_t pwr_nxt;
  logic odt_en;
  logic rdqs_en;
  logic odt_nxt;
  logic [7:0] wr_cnt_r;
  logic [7:0] wr_cnt_nxt;
  logic rd_drive;

  assign odt_en = mr_r[ddr2c_pkg::MR_SEL_EMR1][ddr2c_pkg::EMR1_RTT0_BIT] ||
                  mr_r[ddr2c_pkg::MR_SEL_EMR1][ddr2c_pkg::EMR1_RTT1_BIT];
  assign rdqs_en = mr_r[ddr2c_pkg::MR_SEL_EMR1][ddr2c_pkg::EMR1_RDQS_BIT];
  // Read data is driven only while drivers run; the enable goes low to drive.
  assign rd_drive = RD_VALID && run && cke_s;

  always_comb
  begin
    pwr_nxt.int_clk = (state_nxt == ddr2c_pkg::ST_RUN) || (state_nxt == ddr2c_pkg::ST_WAKE);
    pwr_nxt.out_drv = (state_nxt == ddr2c_pkg::ST_RUN);
    pwr_nxt.in_buf = pwr_nxt.int_clk;
    pwr_nxt.clk_buf = (state_nxt != ddr2c_pkg::ST_SR);
    pwr_nxt.odt_buf = (state_nxt != ddr2c_pkg::ST_SR);
    // Termination is switched by the pin only when the mode register allows it.
    // It follows the next state, so it drops together with the buffers on self-refresh entry.
    odt_nxt = cmd_s.odt && odt_en && (state_nxt != ddr2c_pkg::ST_SR);
    wr_cnt_nxt = (wr_cnt_r != 8'h00) ? wr_cnt_r - 8'h01 : 8'h00;
    if (exec && code == ddr2c_pkg::CMD_WR)
    begin
      wr_cnt_nxt = 8'(BURST_CYC);
    end
  end

  // ----------------------------------------------------------------------------
  // Write masking.
  // ----------------------------------------------------------------------------
  ddr2c_wmask #(.DW(ddr2c_pkg::DQ_W)) u_wmask (
    .clock(CLOCK),
    .resetn(RESETN),
    .clock_en(CLOCK_EN),
    .beat_valid((wr_cnt_r != 8'h00) && run),
    .dm_en(!rdqs_en),
    .dq_rise(beat_s.dq_rise),
    .dq_fall(beat_s.dq_fall),
    .dm_rise(beat_s.dm_rise),
    .dm_fall(beat_s.dm_fall),
    .store_rise(WR_STORE_RISE),
    .store_fall(WR_STORE_FALL),
    .data_rise(WR_DATA_RISE),
    .data_fall(WR_DATA_FALL)
  );

  // ----------------------------------------------------------------------------
  // Registers. Everything freezes while CLOCK_EN is low.
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_r <= ddr2c_pkg::ST_RUN;
      wake_r <= 8'h00;
      open_r <= 8'h00;
      wr_cnt_r <= 8'h00;
      for (int i = 0; i < 4; i++)
      begin
        mr_r[i] <= ddr2c_pkg::MR_RST;
      end
      CMD_STROBE <= 1'b0;
      CMD_CODE <= ddr2c_pkg::CMD_NOP;
      CMD_BANK <= 3'h0;
      CMD_ADDR <= 14'h0000;
      CMD_AUTO_PRE <= 1'b0;
      POWER <= '1;
      ODT_ON <= 1'b0;
      DQ_O_RISE <= 8'h00;
      DQ_O_FALL <= 8'h00;
      DQ_OE_N <= 1'b1;
      RDQS_O <= 1'b0;
      RDQS_OE_N <= 1'b1;
    end
    else if (CLOCK_EN)
    begin
      state_r <= state_nxt;
      wake_r <= wake_nxt;
      open_r <= open_nxt;
      wr_cnt_r <= wr_cnt_nxt;
      mr_r <= mr_nxt;
      // A no-operation is decoded but reported as no command.
      CMD_STROBE <= exec && !cmd_s.cs_n && code != ddr2c_pkg::CMD_NOP;
      CMD_CODE <= code;
      CMD_BANK <= cmd_s.ba;
      CMD_ADDR <= cmd_s.addr;
      CMD_AUTO_PRE <= cmd_s.addr[ddr2c_pkg::AP_BIT];
      POWER <= pwr_nxt;
      ODT_ON <= odt_nxt;
      DQ_O_RISE <= RD_DATA_RISE;
      DQ_O_FALL <= RD_DATA_FALL;
      DQ_OE_N <= !rd_drive;
      // The read strobe leads high on the rising half of each read cycle.
      RDQS_O <= rd_drive && rdqs_en;
      RDQS_OE_N <= !(rd_drive && rdqs_en);
    end
  end

  assign BANK_OPEN = open_r;
  assign MODE_BASE = mr_r[0];
  assign MODE_EXT1 = mr_r[ddr2c_pkg::MR_SEL_EMR1];
  assign PWR_STATE = state_r;

  // ----------------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------------
  property p_cmd_take;
    @(posedge CLOCK) disable iff (!RESETN || !CLOCK_EN)
    (exec && code == ddr2c_pkg::CMD_ACT) |=> CMD_STROBE && CMD_BANK == $past(cmd_s.ba) && BANK_OPEN[CMD_BANK];
  endproperty
  a_cmd_take: assert property (p_cmd_take) else $error("activate not taken");

  property p_cs_mask;
    @(posedge CLOCK) disable iff (!RESETN || !CLOCK_EN)
    cmd_s.cs_n |=> !CMD_STROBE && $stable(BANK_OPEN);
  endproperty
  a_cs_mask: assert property (p_cs_mask) else $error("deselected command acted");

  property p_nop;
    @(posedge CLOCK) disable iff (!RESETN || !CLOCK_EN)
    (code == ddr2c_pkg::CMD_NOP) |=> !CMD_STROBE && $stable(BANK_OPEN) && $stable(MODE_EXT1);
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation changed state");

  property p_pd_active;
    @(posedge CLOCK) disable iff (!RESETN || !CLOCK_EN)
    (run && !cke_s && !all_idle) |=> PWR_STATE == ddr2c_pkg::ST_PDA && !POWER.in_buf && !POWER.out_drv;
  endproperty
  a_pd_active: assert property (p_pd_active) else $error("active power-down not entered");

  property p_pd_bufs;
    @(posedge CLOCK) disable iff (!RESETN || !CLOCK_EN)
    (PWR_STATE == ddr2c_pkg::ST_PDP) |=> (PWR_STATE != ddr2c_pkg::ST_PDP) || (POWER.clk_buf && POWER.odt_buf && !POWER.in_buf);
  endproperty
  a_pd_bufs: assert property (p_pd_bufs) else $error("power-down buffer set wrong");

  property p_sr_bufs;
    @(posedge CLOCK) disable iff (!RESETN || !CLOCK_EN)
    $rose(PWR_STATE == ddr2c_pkg::ST_SR) |-> !POWER.clk_buf && !POWER.odt_buf && !POWER.in_buf && !ODT_ON;
  endproperty
  a_sr_bufs: assert property (p_sr_bufs) else $error("self refresh kept buffers on");

  property p_wake;
    @(posedge CLOCK) disable iff (!RESETN || !CLOCK_EN)
    $rose(PWR_STATE == ddr2c_pkg::ST_WAKE) |-> (!CMD_STROBE && PWR_STATE == ddr2c_pkg::ST_WAKE)[*4] ##1 run;
  endproperty
  a_wake: assert property (p_wake) else $error("commands not held off after wake");

  property p_odt_off;
    @(posedge CLOCK) disable iff (!RESETN || !CLOCK_EN)
    !odt_en |=> !ODT_ON;
  endproperty
  a_odt_off: assert property (p_odt_off) else $error("termination on while disabled");

  property p_pre_all;
    @(posedge CLOCK) disable iff (!RESETN || !CLOCK_EN)
    (exec && code == ddr2c_pkg::CMD_PRE && cmd_s.addr[ddr2c_pkg::AP_BIT]) |=> BANK_OPEN == 8'h00;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

  property p_mrs_ext;
    @(posedge CLOCK) disable iff (!RESETN || !CLOCK_EN)
    (exec && code == ddr2c_pkg::CMD_MRS && all_idle && cmd_s.ba == 3'h1) |=> MODE_EXT1 == $past(cmd_s.addr);
  endproperty
  a_mrs_ext: assert property (p_mrs_ext) else $error("extended mode register not written");

  property p_rdqs;
    @(posedge CLOCK) disable iff (!RESETN || !CLOCK_EN)
    (rd_drive && rdqs_en) |=> !RDQS_OE_N && !DQ_OE_N && DQ_O_FALL == $past(RD_DATA_FALL);
  endproperty
  a_rdqs: assert property (p_rdqs) else $error("read strobe or read beats missing");

endmodule

// *** sim/ddr2c_ctl_model.sv ***
// Behavioural memory controller that drives the command and clock-enable pins.
// Assumes the bench hands it one intent per cycle, changed at the falling edge.
`timescale 1ns/1ps
module ddr2c_ctl_model (
  input wire logic clock,
  input wire logic cke_req,
  input wire ddr2c_pkg::ddr2c_cmd_t cmd_req,
  output logic cke,
  output ddr2c_pkg::ddr2c_cmd_t cmd
);
  logic [1:0] busy_r = 2'h0;
  logic [16:0] last_r = 17'h0;
  // ----------------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------------
  // A read or write holds clock enable up for its burst.
  always @(posedge clock)
  begin
    busy_r <= (!cmd.cs_n && cmd.ras_n && !cmd.cas_n) ? 2'h3 : {1'b0, busy_r[1]};
    last_r <= {cmd.ba, cmd.addr};
  end
  // Deselected address lines toggle, so the device cannot lean on stale values.
  always_comb
  begin
    cke = cke_req | (busy_r != 2'h0);
    cmd = cmd_req;
    if (cmd_req.cs_n)
      {cmd.ba, cmd.addr} = ~last_r;
  end
endmodule

// *** sim/test_ddr2_sdram_control_input_logic.sv ***
// Self-checking bench for the control input logic, with a controller model on the pins.
// Assumes the hand-over latencies: three edges from pin to result.
`timescale 1ns/1ps
module test_ddr2_sdram_control_input_logic;
  logic clock, resetn, cke_req, rd_valid, cke, stb, ap, odt_on, dq_oe_n, rdqs, rdqs_oe_n, st_r, st_f;
  logic [7:0] rdr, rdf, bank_open, dq_r, dq_f, wd_r, wd_f, exp_open;
  logic [13:0] addr_o, mb, me, a;
  logic [3:0] code_o, c;
  logic [2:0] ba_o, b;
  logic [3:0] tbl [6] = '{4'h3, 4'h2, 4'h5, 4'h4, 4'h7, 4'hb};
  ddr2c_pkg::ddr2c_cmd_t req, pins;
  ddr2c_pkg::ddr2c_beat_t beat, b1, b2;
  ddr2c_pkg::ddr2c_power_t pwr;
  ddr2c_pkg::ddr2c_state_t st;
  int err_count = 0, n_tests = 0, cyc = 0, seed = 32'h51c4b37f, i;
  ddr2c_ctl_model u_ctl (.clock(clock), .cke_req(cke_req), .cmd_req(req), .cke(cke), .cmd(pins));
  ddr2c_top u_dut (.CLOCK(clock), .RESETN(resetn), .CLOCK_EN(1'b1), .CKE(cke), .CMD_PINS(pins),
    .WR_BEAT(beat), .RD_VALID(rd_valid), .RD_DATA_RISE(rdr), .RD_DATA_FALL(rdf), .CMD_STROBE(stb),
    .CMD_CODE(code_o), .CMD_BANK(ba_o), .CMD_ADDR(addr_o), .CMD_AUTO_PRE(ap), .BANK_OPEN(bank_open),
    .MODE_BASE(mb), .MODE_EXT1(me), .POWER(pwr), .PWR_STATE(st), .ODT_ON(odt_on), .DQ_O_RISE(dq_r),
    .DQ_O_FALL(dq_f), .DQ_OE_N(dq_oe_n), .RDQS_O(rdqs), .RDQS_OE_N(rdqs_oe_n), .WR_STORE_RISE(st_r),
    .WR_STORE_FALL(st_f), .WR_DATA_RISE(wd_r), .WR_DATA_FALL(wd_f));
  // ----------------------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------------------
  // Free-running 40 MHz clock.
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // The run needs well under a thousand cycles, so five thousand means a hang.
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("COUNTS checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One command for one cycle, then idle until its result has landed.
  task automatic issue(input logic [3:0] cd, input logic [2:0] bk, input logic [13:0] ad);
    {req.cs_n, req.ras_n, req.cas_n, req.we_n} = cd;
    req.ba = bk;
    req.addr = ad;
    @(negedge clock);
    {req.cs_n, req.ras_n, req.cas_n, req.we_n} = ddr2c_pkg::CMD_NOP;
    // The strobe stands for one cycle only, after the third edge from the pins.
    repeat (2) @(negedge clock);
  endtask
  // Bank state expected after one command.
  function automatic logic [7:0] nxt(input logic [3:0] cd, input logic [2:0] bk, input logic a10,
    input logic [7:0] o);
    case (cd)
      4'h3: return o | (8'h01 << bk);
      4'h2: return a10 ? 8'h00 : o & ~(8'h01 << bk);
      4'h4, 4'h5: return a10 ? o & ~(8'h01 << bk) : o;
      default: return o;
    endcase
  endfunction
  // Read beats leave on the next edge; the mask pin strobes only when set up so.
  task automatic rd(input logic ext);
    rd_valid = 1'b1;
    rdr = 8'($random(seed));
    rdf = 8'($random(seed));
    @(negedge clock);
    rd_valid = 1'b0;
    chk("read", {1'b0, rdr, rdf}, {dq_oe_n, dq_r, dq_f});
    chk("rdqs", {~ext, ext}, {rdqs_oe_n, rdqs});
    @(negedge clock);
    chk("read_off", 1'b1, dq_oe_n);
  endtask
  // Two masked or unmasked beats of one write burst.
  task automatic wr(input logic nomask);
    b1 = {16'($random(seed)), 2'($random(seed))};
    b2 = {16'($random(seed)), 2'($random(seed))};
    {req.cs_n, req.ras_n, req.cas_n, req.we_n} = ddr2c_pkg::CMD_WR;
    @(negedge clock);
    {req.cs_n, req.ras_n, req.cas_n, req.we_n} = ddr2c_pkg::CMD_NOP;
    beat = b1;
    @(negedge clock);
    beat = b2;
    @(negedge clock);
    beat = 18'h3;
    @(negedge clock);
    chk("store1", {~b1[1:0] | {2{nomask}}, b1[17:2]}, {st_r, st_f, wd_r, wd_f});
    @(negedge clock);
    chk("store2", {~b2[1:0] | {2{nomask}}, b2[17:2]}, {st_r, st_f, wd_r, wd_f});
  endtask
  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    cke_req = 1'b1;
    req = {ddr2c_pkg::CMD_NOP, 3'h0, 14'h0000, 1'b0};
    beat = 18'h3;
    rd_valid = 1'b0;
    rdr = 8'h00;
    rdf = 8'h00;
    exp_open = 8'h00;
    repeat (20) @(negedge clock);
    resetn = 1'b1;
    repeat (6) @(negedge clock);
    for (i = 0; i < 40; i++)
    begin
      c = tbl[$unsigned($random(seed)) % 6];
      b = 3'($random(seed));
      a = 14'($random(seed));
      issue(c, b, a);
      exp_open = nxt(c, b, a[10], exp_open);
      chk("strobe", c < 4'h6, stb);
      chk("code", c, code_o);
      chk("banks", exp_open, bank_open);
      if (!c[3])
        chk("bank_addr", {b, a[10], a}, {ba_o, ap, addr_o});
    end
    $display("DONE commands");
    issue(4'h2, 3'h0, 14'h0400);
    req.odt = 1'b1;
    repeat (2) @(negedge clock);
    chk("odt_off", 1'b0, odt_on);
    a = 14'($random(seed));
    issue(4'h0, 3'h0, a);
    chk("mode_base", a, mb);
    issue(4'h0, 3'h1, 14'h0044);
    @(negedge clock);
    chk("odt_on", 15'h4044, {odt_on, me});
    rd(1'b0);
    for (i = 0; i < 4; i++)
      wr(1'b0);
    $display("DONE modes read write");
    cke_req = 1'b0;
    issue(4'h3, 3'h2, 14'h0001);
    chk("pd_prech", {ddr2c_pkg::ST_PDP, 5'h06, 8'h00}, {st, pwr, bank_open});
    cke_req = 1'b1;
    repeat (4) @(negedge clock);
    chk("pd_exit", {ddr2c_pkg::ST_RUN, 5'h1f}, {st, pwr});
    issue(4'h3, 3'h5, 14'h0002);
    cke_req = 1'b0;
    repeat (4) @(negedge clock);
    chk("pd_act", {ddr2c_pkg::ST_PDA, 5'h06}, {st, pwr});
    cke_req = 1'b1;
    repeat (4) @(negedge clock);
    issue(4'h2, 3'h0, 14'h0400);
    cke_req = 1'b0;
    issue(ddr2c_pkg::CMD_REF, 3'h0, 14'h0000);
    chk("self_ref", {ddr2c_pkg::ST_SR, 5'h00, 1'b0}, {st, pwr, odt_on});
    cke_req = 1'b1;
    repeat (3) @(negedge clock);
    issue(4'h3, 3'h1, 14'h0003);
    chk("wake", {ddr2c_pkg::ST_WAKE, 5'h1e, 9'h0}, {st, pwr, stb, bank_open});
    repeat (4) @(negedge clock);
    chk("wake_end", ddr2c_pkg::ST_RUN, st);
    $display("DONE power");
    issue(4'h0, 3'h1, 14'h0800);
    rd(1'b1);
    wr(1'b1);
    $display("DONE read strobe");
    close_out();
  end
endmodule
